// ---- src/hbp_host_port.sv ----
// Host bus pin interface: PCI target and bus master, or VL target.
// Assumes the bus pins share core_clk; the strap pin is asynchronous.
//
// What this block does
// [RQ1] Strap at power-on selects PCI or VL; shared pins follow that bus.
// [RQ2] PCI transaction: one address phase, then one or more data phases.
// [RQ3] VL host drives word address 22:2; data on separate two-way bus.
// [RQ4] Relocated VL: first low, second high means register or port access.
// [RQ5] Relocated VL: first high, second low means video memory access.
// [RQ6] Relocated VL: both upper-decode inputs equal, no response.
// [RQ7] PCI command lines carry command in address, byte enables in data.
// [RQ8] During own DMA on PCI, device drives command/byte-enable lines.
// [RQ9] Everything on the bus clock; reset returns all to idle.
`timescale 1ns/1ns
module hbp_host_port import hbp_pkg::*; (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic bus_mode_strap,
  input wire logic vl_relocated,
  input wire logic [31:0] pci_ad_in,
  output logic [31:0] pci_ad_out_r,
  output logic pci_ad_oe_b_r,
  input wire logic [3:0] pci_cbe_in,
  output logic [3:0] pci_cbe_out_r,
  output logic pci_cbe_oe_b_r,
  input wire logic pci_frame_b,
  input wire logic pci_phase_done_b,
  input wire logic pci_target_sel,
  input wire logic [HBP_VL_AHI:HBP_VL_ALO] vl_word_address_lines,
  input wire logic [31:0] vl_data_lines_in,
  output logic [31:0] vl_data_lines_out_r,
  output logic vl_data_lines_oe_b_r,
  input wire logic [3:0] vl_byte_enable_lines,
  input wire logic upper_decode_first,
  input wire logic upper_decode_second,
  input wire logic vl_addr_strobe_b,
  input wire logic vl_write,
  input wire logic vl_mem_io,
  input wire logic vl_cycle_end_b,
  input wire logic [31:0] core_rdata,
  input wire logic core_rdata_valid,
  input wire logic dma_start,
  input wire hbp_dma_req_t dma_req,
  output logic dma_busy_r,
  output logic dma_done_r,
  output logic vl_mode_r,
  output logic cycle_valid_r,
  output hbp_cycle_t cycle_r
);

  //////////////////////////////////////////////////////////////////////////
  // Strap capture
  logic strap_s1_r;
  logic strap_s2_r;
  logic strap_taken_r;

  // Strap pin is async: two flops first, then taken once after release
  always_ff @(posedge core_clk) begin
    strap_s1_r <= bus_mode_strap;
    strap_s2_r <= strap_s1_r;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin // see [RQ9]
      strap_taken_r <= 1'b0;
      vl_mode_r <= HBP_MODE_RST;
    end else if (!strap_taken_r) begin
      strap_taken_r <= 1'b1;
      vl_mode_r <= (strap_s2_r == HBP_STRAP_VL); // see [RQ1]
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Target side state
  hbp_tgt_state_t tgt_r;
  hbp_tgt_state_t tgt_nxt;
  hbp_mst_state_t mst_r;
  hbp_mst_state_t mst_nxt;
  logic [31:0] tgt_addr_r;
  logic vl_read_pend_r;
  logic [3:0] vl_be_r;
  logic vl_wr_r;
  logic dec_hit;
  logic dec_mem;
  logic dec_reg;
  logic pci_ready;
  logic vl_strobe;

  // Modes never mix: PCI logic is held off until the strap is taken
  assign pci_ready = strap_taken_r && !vl_mode_r;
  assign vl_strobe = strap_taken_r && vl_mode_r && !vl_addr_strobe_b && (tgt_r == HBP_T_IDLE);

  hbp_upper_decode u_dec (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .strobe(vl_strobe),
    .relocated(vl_relocated),
    .mem_io(vl_mem_io),
    .upper_decode_first(upper_decode_first),
    .upper_decode_second(upper_decode_second),
    .hit_r(dec_hit),
    .is_mem_r(dec_mem),
    .is_reg_r(dec_reg)
  );

  always_comb begin
    tgt_nxt = tgt_r;
    case (tgt_r)
      HBP_T_IDLE: begin
        if (pci_ready && !pci_frame_b && pci_target_sel && mst_r == HBP_M_IDLE) begin
          tgt_nxt = HBP_T_DATA; // see [RQ2]
        end else if (dec_hit) begin
          tgt_nxt = HBP_T_VL;
        end
      end
      HBP_T_DATA: begin
        if (!pci_phase_done_b && pci_frame_b) begin
          tgt_nxt = HBP_T_IDLE; // see [RQ2]
        end
      end
      HBP_T_VL: begin
        if (!vl_cycle_end_b) begin
          tgt_nxt = HBP_T_IDLE;
        end
      end
      default: tgt_nxt = HBP_T_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin // see [RQ9]
      tgt_r <= HBP_T_IDLE;
    end else begin
      tgt_r <= tgt_nxt;
    end
  end

  // VL address and enables held from the strobe until decode lands
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      tgt_addr_r <= HBP_WORD_RST;
      vl_be_r <= HBP_NIB_RST;
      vl_wr_r <= 1'b0;
    end else if (vl_strobe) begin
      tgt_addr_r <= {9'h000, vl_word_address_lines, 2'h0}; // see [RQ3]
      vl_be_r <= vl_byte_enable_lines;
      vl_wr_r <= vl_write;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Cycles reported to the core
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin // see [RQ9]
      cycle_valid_r <= 1'b0;
      cycle_r <= '0;
    end else begin
      cycle_valid_r <= 1'b0;
      if (tgt_r == HBP_T_IDLE && tgt_nxt == HBP_T_DATA) begin
        cycle_valid_r <= 1'b1;
        cycle_r.addr <= pci_ad_in;
        cycle_r.cmd <= pci_cbe_in; // see [RQ7]
        cycle_r.is_addr <= 1'b1;
        cycle_r.is_write <= pci_cbe_in[0];
        cycle_r.is_mem <= 1'b0;
        cycle_r.is_reg <= 1'b0;
      end else if (tgt_r == HBP_T_DATA && !pci_phase_done_b) begin
        cycle_valid_r <= 1'b1;
        cycle_r.data <= pci_ad_in;
        cycle_r.be <= pci_cbe_in; // see [RQ7]
        cycle_r.is_addr <= 1'b0;
      end else if (tgt_r == HBP_T_IDLE && dec_hit) begin
        // VL write data is sampled here, the cycle after the strobe
        cycle_valid_r <= 1'b1;
        cycle_r.addr <= tgt_addr_r;
        cycle_r.data <= vl_data_lines_in; // see [RQ3]
        cycle_r.be <= vl_be_r;
        cycle_r.cmd <= HBP_NIB_RST;
        cycle_r.is_addr <= 1'b1;
        cycle_r.is_write <= vl_wr_r;
        cycle_r.is_mem <= dec_mem; // see [RQ5]
        cycle_r.is_reg <= dec_reg; // see [RQ4]
      end
    end
  end

  // VL read data held on the bus until the host ends the cycle
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin // see [RQ9]
      vl_data_lines_out_r <= HBP_WORD_RST;
      vl_data_lines_oe_b_r <= HBP_OE_OFF;
      vl_read_pend_r <= 1'b0;
    end else begin
      if (tgt_r == HBP_T_IDLE && dec_hit && !vl_wr_r) begin
        vl_read_pend_r <= 1'b1;
      end else if (tgt_r == HBP_T_VL && vl_read_pend_r && core_rdata_valid) begin
        vl_read_pend_r <= 1'b0;
        vl_data_lines_out_r <= core_rdata;
        vl_data_lines_oe_b_r <= 1'b0; // see [RQ3]
      end
      if (tgt_r == HBP_T_VL && !vl_cycle_end_b) begin
        vl_data_lines_oe_b_r <= HBP_OE_OFF;
        vl_read_pend_r <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Bus-master DMA on PCI
  hbp_dma_req_t dma_hold_r;

  always_comb begin
    mst_nxt = mst_r;
    case (mst_r)
      HBP_M_IDLE: begin
        if (pci_ready && dma_start && tgt_r == HBP_T_IDLE && pci_frame_b) begin
          mst_nxt = HBP_M_ADDR;
        end
      end
      HBP_M_ADDR: mst_nxt = HBP_M_DATA; // see [RQ2]
      HBP_M_DATA: begin
        if (!pci_phase_done_b) begin
          mst_nxt = HBP_M_IDLE;
        end
      end
      default: mst_nxt = HBP_M_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin // see [RQ9]
      mst_r <= HBP_M_IDLE;
      dma_hold_r <= '0;
      dma_busy_r <= 1'b0;
      dma_done_r <= 1'b0;
    end else begin
      mst_r <= mst_nxt;
      dma_busy_r <= (mst_nxt != HBP_M_IDLE);
      dma_done_r <= (mst_r == HBP_M_DATA) && (mst_nxt == HBP_M_IDLE);
      if (mst_r == HBP_M_IDLE && mst_nxt == HBP_M_ADDR) begin
        dma_hold_r <= dma_req;
      end
    end
  end

  // Pin drivers follow the next state so they line up with the phase
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin // see [RQ9]
      pci_ad_out_r <= HBP_WORD_RST;
      pci_ad_oe_b_r <= HBP_OE_OFF;
      pci_cbe_out_r <= HBP_NIB_RST;
      pci_cbe_oe_b_r <= HBP_OE_OFF;
    end else begin
      case (mst_nxt)
        HBP_M_ADDR: begin
          pci_ad_out_r <= dma_req.addr;
          pci_cbe_out_r <= dma_req.cmd; // see [RQ7]
          pci_ad_oe_b_r <= 1'b0;
          pci_cbe_oe_b_r <= 1'b0; // see [RQ8]
        end
        HBP_M_DATA: begin
          pci_ad_out_r <= dma_hold_r.data;
          pci_cbe_out_r <= dma_hold_r.be; // see [RQ7]
          pci_ad_oe_b_r <= 1'b0;
          pci_cbe_oe_b_r <= 1'b0; // see [RQ8]
        end
        default: begin
          pci_ad_oe_b_r <= HBP_OE_OFF;
          pci_cbe_oe_b_r <= HBP_OE_OFF;
        end
      endcase
    end
  end

endmodule // hbp_host_port

// ---- src/hbp_pkg.sv ----
// Shared constants, states and carriers for the host bus pin interface.
// Assumes one bus clock drives both the pins and the core side.
package hbp_pkg;

  localparam int HBP_AW = 32;
  localparam int HBP_DW = 32;
  localparam int HBP_BEW = 4;
  localparam int HBP_VL_AHI = 22;
  localparam int HBP_VL_ALO = 2;
  localparam int HBP_VL_AW = HBP_VL_AHI - HBP_VL_ALO + 1;

  // Reset values
  localparam logic HBP_MODE_RST = 1'b0;
  localparam logic HBP_OE_OFF = 1'b1;
  localparam logic [31:0] HBP_WORD_RST = 32'h0000_0000;
  localparam logic [3:0] HBP_NIB_RST = 4'h0;

  // Strap encoding: low selects PCI, high selects VL
  localparam logic HBP_STRAP_VL = 1'b1;

  typedef enum logic [1:0] {
    HBP_T_IDLE = 2'b00,
    HBP_T_DATA = 2'b01,
    HBP_T_VL = 2'b10
  } hbp_tgt_state_t;

  typedef enum logic [1:0] {
    HBP_M_IDLE = 2'b00,
    HBP_M_ADDR = 2'b01,
    HBP_M_DATA = 2'b10
  } hbp_mst_state_t;

  // One decoded host access handed to the core
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    logic [3:0] cmd;
    logic [3:0] be;
    logic is_addr;
    logic is_mem;
    logic is_reg;
    logic is_write;
  } hbp_cycle_t;

  // One bus-master transfer asked for by the core
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    logic [3:0] cmd;
    logic [3:0] be;
  } hbp_dma_req_t;

endpackage

// ---- src/hbp_upper_decode.sv ----
// Registered VL upper-address decode.
// Assumes pins are synchronous to core_clk and sampled on the strobe cycle.
`timescale 1ns/1ns
module hbp_upper_decode import hbp_pkg::*; (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic strobe,
  input wire logic relocated,
  input wire logic mem_io,
  input wire logic upper_decode_first,
  input wire logic upper_decode_second,
  output logic hit_r,
  output logic is_mem_r,
  output logic is_reg_r
);

  //////////////////////////////////////////////////////////////////////////
  function automatic logic [1:0] kind(input logic rel, input logic mio, input logic u1, input logic u2);
    logic [1:0] k;
    k = {mio, ~mio};
    if (rel) begin
      case ({u1, u2})
        2'b01: k = 2'b01; // see [RQ4]
        2'b10: k = 2'b10; // see [RQ5]
        default: k = 2'b00; // see [RQ6]
      endcase
    end
    return k;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin // see [RQ9]
      hit_r <= 1'b0;
      is_mem_r <= 1'b0;
      is_reg_r <= 1'b0;
    end else begin
      hit_r <= strobe && (kind(relocated, mem_io, upper_decode_first, upper_decode_second) != 2'b00);
      {is_mem_r, is_reg_r} <= kind(relocated, mem_io, upper_decode_first, upper_decode_second);
    end
  end

endmodule // hbp_upper_decode

// ---- test/hbp_host_model.sv ----
// Host controller model: completes the data phase of device DMA.
// Assumes the device holds dma_busy_r from address phase to done.
`timescale 1ns/1ns
module hbp_host_model (
  input wire logic core_clk,
  input wire logic dma_busy_r,
  input wire logic [3:0] wait_cycles,
  output logic phase_done_b
);
  logic [4:0] cnt_r;
  // Counts address phase, then stalls the data phase
  always_ff @(posedge core_clk) begin
    if (!dma_busy_r) begin
      cnt_r <= 5'h00;
    end else begin
      cnt_r <= cnt_r + 5'h01;
    end
  end
  assign phase_done_b = !(dma_busy_r && cnt_r == {1'b0, wait_cycles} + 5'h01);
endmodule // hbp_host_model

// ---- test/hbp_port_sva.sv ----
// Checker for the host bus pin interface ports.
// Assumes it is bound to hbp_host_port and sees only its ports.
`timescale 1ns/1ns
module hbp_port_sva import hbp_pkg::*; (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic vl_relocated,
  input wire logic [31:0] pci_ad_in,
  input wire logic [3:0] pci_cbe_in,
  input wire logic [3:0] pci_cbe_out_r,
  input wire logic pci_cbe_oe_b_r,
  input wire logic pci_frame_b,
  input wire logic pci_phase_done_b,
  input wire logic pci_target_sel,
  input wire logic upper_decode_first,
  input wire logic upper_decode_second,
  input wire logic vl_addr_strobe_b,
  input wire logic vl_data_lines_oe_b_r,
  input wire hbp_dma_req_t dma_req,
  input wire logic dma_busy_r,
  input wire logic dma_done_r,
  input wire logic vl_mode_r,
  input wire logic cycle_valid_r,
  input wire hbp_cycle_t cycle_r
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////
  // Decode outcome two edges after a relocated strobe
  property vl_p(logic f, logic s, logic r, logic m);
    vl_mode_r && !vl_addr_strobe_b && vl_relocated && upper_decode_first == f && upper_decode_second == s
      |-> ##2 cycle_valid_r == (r | m) && (!cycle_valid_r || (cycle_r.is_reg == r && cycle_r.is_mem == m));
  endproperty
  reset_idle_a: assert property (disable iff (1'b0) !rst_b |=> pci_cbe_oe_b_r && vl_data_lines_oe_b_r
    && !dma_busy_r && !cycle_valid_r) else $error("outputs not idle after reset");
  pci_addr_a: assert property ($fell(pci_frame_b) && pci_target_sel && !vl_mode_r && !dma_busy_r
    |=> cycle_valid_r && cycle_r.is_addr && cycle_r.addr == $past(pci_ad_in) && cycle_r.cmd == $past(pci_cbe_in))
    else $error("address phase not reported");
  pci_data_a: assert property (cycle_valid_r && !cycle_r.is_addr && !vl_mode_r |-> !$past(pci_phase_done_b)
    && cycle_r.be == $past(pci_cbe_in) && cycle_r.data == $past(pci_ad_in)) else $error("data phase mismatch");
  dma_cmd_a: assert property ($rose(dma_busy_r) |-> !pci_cbe_oe_b_r && pci_cbe_out_r == $past(dma_req.cmd)
    ##1 !pci_cbe_oe_b_r && pci_cbe_out_r == $past(dma_req.be, 2)) else $error("dma command lines wrong");
  dma_end_a: assert property ($fell(dma_busy_r) |-> dma_done_r && pci_cbe_oe_b_r && !$past(pci_phase_done_b))
    else $error("dma ended wrongly");
  vl_reg_a: assert property (vl_p(1'b0, 1'b1, 1'b1, 1'b0)) else $error("register decode wrong");
  vl_mem_a: assert property (vl_p(1'b1, 1'b0, 1'b0, 1'b1)) else $error("memory decode wrong");
  vl_low_a: assert property (vl_p(1'b0, 1'b0, 1'b0, 1'b0)) else $error("response to low pair");
  vl_high_a: assert property (vl_p(1'b1, 1'b1, 1'b0, 1'b0)) else $error("response to high pair");
  cover property (dma_done_r);
  cover property (cycle_valid_r && !cycle_r.is_addr ##1 cycle_valid_r && !cycle_r.is_addr);
  cover property (cycle_valid_r && cycle_r.is_reg);
  cover property (cycle_valid_r && cycle_r.is_mem);
endmodule // hbp_port_sva

// ---- test/test_host_bus_pin_interface.sv ----
// Testbench: PCI target and DMA, then VL decode and read.
// Assumes the checker and host model are compiled first.
`timescale 1ns/1ns
module test_host_bus_pin_interface import hbp_pkg::*;;
  logic clk, rst_b, strap, reloc, frame_b, done_t, sel, strobe_b, wr, mio, end_b, rvalid, start, udf, uds;
  logic ad_oe, cbe_oe, vd_oe, busy, done, mode, cvalid, done_m;
  logic [31:0] ad_host, ad_out, vd_out, rdata;
  logic [3:0] cbe_host, cbe_out, vbe, dwait;
  logic [20:0] vaddr;
  hbp_dma_req_t req;
  hbp_cycle_t cyc;
  int fails, n_checks;
  wire logic [31:0] ad_w = ad_oe ? ad_host : ad_out;
  wire logic [3:0] cbe_w = cbe_oe ? cbe_host : cbe_out;
  wire logic [31:0] vd_w = vd_oe ? ad_host : vd_out;
  wire logic done_b = done_t & done_m;
  hbp_host_port dut (.core_clk(clk), .rst_b(rst_b), .bus_mode_strap(strap), .vl_relocated(reloc),
    .pci_ad_in(ad_w), .pci_ad_out_r(ad_out), .pci_ad_oe_b_r(ad_oe), .pci_cbe_in(cbe_w), .pci_cbe_out_r(cbe_out),
    .pci_cbe_oe_b_r(cbe_oe), .pci_frame_b(frame_b), .pci_phase_done_b(done_b), .pci_target_sel(sel),
    .vl_word_address_lines(vaddr), .vl_data_lines_in(vd_w), .vl_data_lines_out_r(vd_out),
    .vl_data_lines_oe_b_r(vd_oe), .vl_byte_enable_lines(vbe), .upper_decode_first(udf),
    .upper_decode_second(uds), .vl_addr_strobe_b(strobe_b), .vl_write(wr), .vl_mem_io(mio),
    .vl_cycle_end_b(end_b), .core_rdata(rdata), .core_rdata_valid(rvalid), .dma_start(start), .dma_req(req),
    .dma_busy_r(busy), .dma_done_r(done), .vl_mode_r(mode), .cycle_valid_r(cvalid), .cycle_r(cyc));
  hbp_host_model host (.core_clk(clk), .dma_busy_r(busy), .wait_cycles(dwait), .phase_done_b(done_m));
  ////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] s, input logic [31:0] e, input string m);
    n_checks++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic results();
    if (fails == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic do_reset(input logic s);
    rst_b = 1'b0;
    strap = s;
    repeat (6) @(negedge clk);
    rst_b = 1'b1;
    repeat (2) @(negedge clk);
    check(mode, s, "mode");
    check(ad_oe & cbe_oe & vd_oe & !busy, 1, "idle");
  endtask
  // Frame stays low until the last of nd data phases
  task automatic pci_tgt(input logic [31:0] a, input logic [31:0] d, input logic [3:0] c, input logic [3:0] b,
    input int nd);
    frame_b = 1'b0;
    sel = 1'b1;
    ad_host = a;
    cbe_host = c;
    @(negedge clk);
    check(cvalid && cyc.is_addr, 1, "addr valid");
    check(cyc.addr, a, "addr");
    check(cyc.cmd, c, "cmd");
    check(cyc.is_write, c[0], "write flag");
    sel = 1'b0;
    done_t = 1'b0;
    for (int k = 0; k < nd; k++) begin
      frame_b = (k == nd - 1);
      ad_host = d + k;
      cbe_host = b ^ k[3:0];
      @(negedge clk);
      check(cvalid && !cyc.is_addr, 1, "data valid");
      check(cyc.data, d + k, "data");
      check(cyc.be, b ^ k[3:0], "byte enables");
    end
    done_t = 1'b1;
  endtask
  task automatic dma(input logic [31:0] a, input logic [31:0] d, input logic [3:0] c, input logic [3:0] b,
    input logic [3:0] w);
    int n;
    dwait = w;
    req = '{addr: a, data: d, cmd: c, be: b};
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    check({ad_oe, cbe_oe, cbe_out, busy}, {2'h0, c, 1'b1}, "dma addr phase");
    check(ad_out, a, "dma addr");
    @(negedge clk);
    check(ad_out, d, "dma data");
    check({ad_oe, cbe_oe, cbe_out}, {2'h0, b}, "dma byte enables");
    n = 0;
    while (done !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    check(n, w + 1, "dma stall");
    check({ad_oe, cbe_oe, busy}, 3'h6, "dma release");
  endtask
  // Host side of one VL cycle; a write must never turn the data lines round
  task automatic vl(input logic f, input logic s, input logic rel, input logic m, input logic v, input logic r,
    input logic w);
    udf = f;
    uds = s;
    reloc = rel;
    mio = m;
    wr = w;
    vaddr = 21'h1ABCDE ^ {19'h00000, f, s};
    rdata = {11'h000, vaddr} ^ 32'hF0F0_0000;
    vbe = {f, s, rel, w};
    ad_host = ~rdata;
    strobe_b = 1'b0;
    @(negedge clk);
    strobe_b = 1'b1;
    @(negedge clk);
    check(cvalid, v, "vl response");
    if (v) begin
      check({cyc.is_reg, cyc.is_mem}, {r, !r}, "vl decode");
      check(cyc.addr, {9'h000, vaddr, 2'h0}, "vl addr");
      check(cyc.data, ~rdata, "vl data in");
      check({cyc.be, cyc.is_write}, {vbe, w}, "vl enables");
      rvalid = 1'b1;
      @(negedge clk);
      rvalid = 1'b0;
      @(negedge clk);
      check(vd_oe, w, "vl drive");
      if (!w) begin
        check(vd_out, rdata, "vl read data");
      end
      end_b = 1'b0;
      @(negedge clk);
      end_b = 1'b1;
      @(negedge clk);
      check(vd_oe, 1, "vl release");
    end
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Generous bound; the whole sequence needs under a hundred cycles
  initial begin
    #20000;
    fails++;
    results();
  end
  initial begin
    {rst_b, strap, reloc, wr, mio, rvalid, start, udf, uds, sel} = 10'h000;
    {frame_b, done_t, strobe_b, end_b} = 4'hF;
    {ad_host, rdata, cbe_host, vbe, dwait, vaddr} = '0;
    req = '0;
    do_reset(1'b0);
    pci_tgt(32'h1234_5678, 32'hCAFE_F00D, 4'h7, 4'h3, 1);
    pci_tgt(32'h8000_0004, 32'h0000_FFFF, 4'h6, 4'hC, 3);
    dma(32'h0010_0000, 32'hDEAD_BEEF, 4'h7, 4'h0, 4'h0);
    dma(32'h0020_0040, 32'h5555_AAAA, 4'h6, 4'hF, 4'h3);
    do_reset(1'b1);
    frame_b = 1'b0;
    sel = 1'b1;
    start = 1'b1;
    @(negedge clk);
    {frame_b, sel, start} = 3'h4;
    check({cvalid, busy}, 0, "pci refused in vl");
    vl(1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
    vl(1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1);
    vl(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
    vl(1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
    vl(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1);
    vl(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
    results();
  end
endmodule // test_host_bus_pin_interface
bind hbp_host_port hbp_port_sva chk (.core_clk, .rst_b, .vl_relocated, .pci_ad_in, .pci_cbe_in, .pci_cbe_out_r,
  .pci_cbe_oe_b_r, .pci_frame_b, .pci_phase_done_b, .pci_target_sel, .upper_decode_first, .upper_decode_second,
  .vl_addr_strobe_b, .vl_data_lines_oe_b_r, .dma_req, .dma_busy_r, .dma_done_r, .vl_mode_r, .cycle_valid_r, .cycle_r);
